//--- rtl/shsc_pkg.sv
// Shared constants and types of the standby halt/stop controller
package shsc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [15:0] SEL_ADDR  = 16'hFFFA;
  localparam logic [7:0]  SEL_RESET = 8'h04;
  localparam int          SEL_LSB   = 0;
  localparam int          SEL_W     = 3;

  // ------------------------------------------------------------------
  // Settle-time codes
  // ------------------------------------------------------------------
  localparam logic [2:0] CODE_SHORT = 3'h0;
  localparam logic [2:0] CODE_MID   = 3'h2;
  localparam logic [2:0] CODE_LONG  = 3'h4;

  // ------------------------------------------------------------------
  // Settle times in oscillator periods, one period per clock
  // ------------------------------------------------------------------
  localparam int CLK_PER_OSC     = 1;
  localparam int SETTLE_SHORT_PER = 4096;
  localparam int SETTLE_MID_PER   = 32768;
  localparam int SETTLE_LONG_PER  = 131072;
  localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_PER * CLK_PER_OSC;
  localparam int SETTLE_MID_CYC   = SETTLE_MID_PER * CLK_PER_OSC;
  localparam int SETTLE_LONG_CYC  = SETTLE_LONG_PER * CLK_PER_OSC;

  // ------------------------------------------------------------------
  // Resume latency after a HALT release, in CPU clocks
  // ------------------------------------------------------------------
  localparam int         CLK_PER_CPU   = 1;
  localparam int         VEC_WAIT_CLK  = 9;
  localparam int         NEXT_WAIT_CLK = 1;
  localparam logic [3:0] VEC_LOAD  = 4'(VEC_WAIT_CLK * CLK_PER_CPU - 1);
  localparam logic [3:0] NEXT_LOAD = 4'(NEXT_WAIT_CLK * CLK_PER_CPU - 1);

  // ------------------------------------------------------------------
  // Controller states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_OSC_WAIT,
    ST_SETTLE,
    ST_RESUME
  } shsc_state_t;

endpackage

//--- rtl/shsc_req_sample.sv
// Samples the wake-up sources on the oscillator clock
`timescale 1ns/1ns
module shsc_req_sample #(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Raw sources
  input  wire logic [N-1:0] irq_req,
  input  wire logic [N-1:0] irq_mask,
  input  wire logic         nmi_req,
  input  wire logic         ie_in,
  input  wire logic         nmi_clear,
  // Sampled view
  output logic              unmasked_q,
  output logic              nmi_pend,
  output logic              ie_q
);

  if (N < 1) begin : g_chk
    $error("shsc_req_sample: N must be at least 1");
  end

  // Sticky NMI; a new request beats the clear so none is lost
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      unmasked_q <= 1'b0;
      nmi_pend   <= 1'b0;
      ie_q       <= 1'b0;
    end else begin
      unmasked_q <= |(irq_req & ~irq_mask);
      nmi_pend   <= nmi_req | (nmi_pend & ~nmi_clear);
      ie_q       <= ie_in;
    end
  end

  a_nmi_kept: assert property (@(posedge clock) disable iff (sys_rst)
    nmi_req |=> nmi_pend)
    else $error("NMI request lost at sampling");

endmodule

//--- rtl/shsc_settle_timer.sv
// Oscillator stabilisation counter with power-of-two limits
`timescale 1ns/1ns
module shsc_settle_timer #(
  parameter int CNT_W     = 17,
  parameter int SHORT_CYC = shsc_pkg::SETTLE_SHORT_CYC,
  parameter int MID_CYC   = shsc_pkg::SETTLE_MID_CYC,
  parameter int LONG_CYC  = shsc_pkg::SETTLE_LONG_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       start,
  input  wire logic [2:0] code,
  input  wire logic       run,
  // Status
  output logic            done,
  output logic            busy
);

  if (SHORT_CYC < 1 || MID_CYC < 1 || LONG_CYC < 1 ||
      LONG_CYC > 2**CNT_W || MID_CYC > 2**CNT_W ||
      SHORT_CYC > 2**CNT_W) begin : g_chk
    $error("shsc_settle_timer: counts do not fit CNT_W");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] lim_r;
  logic             hit;
  logic             busy_r;

  // Prohibited codes fall back to the longest, safest wait
  function automatic logic [CNT_W-1:0] settle_limit(input logic [2:0] c);
    case (c)
      shsc_pkg::CODE_SHORT: settle_limit = CNT_W'(SHORT_CYC - 1);
      shsc_pkg::CODE_MID:   settle_limit = CNT_W'(MID_CYC - 1);
      default:              settle_limit = CNT_W'(LONG_CYC - 1);
    endcase
  endfunction

  // Terminal count only while oscillation is confirmed
  assign hit  = busy && run && (cnt_r == lim_r);
  assign busy = busy_r;

  // ------------------------------------------------------------------
  // Counter; out of reset it is armed with the fixed reset length
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r  <= '0;
      lim_r  <= CNT_W'(MID_CYC - 1);
      busy_r <= 1'b1;
      done   <= 1'b0;
    end else begin
      done <= hit;
      if (start) begin
        cnt_r  <= '0;
        lim_r  <= settle_limit(code);
        busy_r <= 1'b1;
      end else if (hit) begin
        cnt_r  <= '0;
        busy_r <= 1'b0;
      end else if (busy_r && run) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  a_count_frozen: assert property (@(posedge clock) disable iff (sys_rst)
    busy_r && !run && !start |=> $stable(cnt_r))
    else $error("Settle count moved before oscillation");

  a_done_at_limit: assert property (@(posedge clock) disable iff (sys_rst)
    done |-> $past(cnt_r) == $past(lim_r))
    else $error("Settle done away from its limit");

endmodule

//--- rtl/shsc_standby_ctrl.sv
// Standby controller: HALT and STOP entry, wake-up and settling
`timescale 1ns/1ns
module shsc_standby_ctrl #(
  parameter int N_IRQ     = 8,
  parameter int CNT_W     = 17,
  parameter int SHORT_CYC = shsc_pkg::SETTLE_SHORT_CYC,
  parameter int MID_CYC   = shsc_pkg::SETTLE_MID_CYC,
  parameter int LONG_CYC  = shsc_pkg::SETTLE_LONG_CYC
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // CPU instruction strobes and flags
  input  wire logic             halt_exec,
  input  wire logic             stop_exec,
  input  wire logic             interrupt_enable_flag,
  // Interrupt sources
  input  wire logic [N_IRQ-1:0] irq_req,
  input  wire logic [N_IRQ-1:0] interrupt_mask_flag,
  input  wire logic             nmi_req,
  // Oscillator
  input  wire logic             osc_running,
  output logic                  osc_enable,
  // Register port
  input  wire logic [15:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // CPU control
  output logic                  cpu_clk_en,
  output logic                  wake_vectored,
  output logic                  wake_next,
  output logic                  reset_branch,
  // Peripheral clock choices
  input  wire logic             timer_external_count_input_sel,
  input  wire logic             serial_ext_clk_sel,
  // Peripheral run enables
  output logic                  timer16_run,
  output logic                  timer8_run,
  output logic                  wdt_run,
  output logic                  serial_run,
  output logic                  ext_int_run,
  // Mode status
  output logic                  halt_mode,
  output logic                  stop_mode
);

  if (N_IRQ < 1 || CNT_W < 13) begin : g_chk
    $error("shsc_standby_ctrl: N_IRQ or CNT_W too small");
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  shsc_pkg::shsc_state_t state_r;
  shsc_pkg::shsc_state_t state_nxt;
  logic [2:0] osc_settle_select_r;
  logic [3:0] resume_cnt_r;
  logic [3:0] resume_cnt_nxt;
  logic       resume_vec_r;
  logic       resume_vec_nxt;
  logic       from_reset_r;
  logic       unmasked_q;
  logic       nmi_pend;
  logic       ie_q;
  logic       settle_done;
  logic       settle_busy;
  logic       settle_start;
  logic       settle_run;
  logic       sel_hit;
  logic       sel_wr;
  logic       resume_end;
  logic       stop_like_nxt;
  logic       nmi_clear;
  logic       halt_wake;
  logic       halt_wake_vec;
  logic       stop_pend_go;
  logic       halt_hold_r;
  logic       settle_code_bit2;
  logic       settle_code_bit1;
  logic       settle_code_bit0;

  // ------------------------------------------------------------------
  // Wake source sampling
  // ------------------------------------------------------------------
  shsc_req_sample #(
    .N (N_IRQ)
  ) u_sample (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .irq_req    (irq_req),
    .irq_mask   (interrupt_mask_flag),
    .nmi_req    (nmi_req),
    .ie_in      (interrupt_enable_flag),
    .nmi_clear  (nmi_clear),
    .unmasked_q (unmasked_q),
    .nmi_pend   (nmi_pend),
    .ie_q       (ie_q)
  );

  // ------------------------------------------------------------------
  // Stabilisation timer
  // ------------------------------------------------------------------
  shsc_settle_timer #(
    .CNT_W     (CNT_W),
    .SHORT_CYC (SHORT_CYC),
    .MID_CYC   (MID_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_settle (
    .clock   (clock),
    .sys_rst (sys_rst),
    .start   (settle_start),
    .code    (osc_settle_select_r),
    .run     (settle_run),
    .done    (settle_done),
    .busy    (settle_busy)
  );

  // Register decode and field view
  assign sel_hit          = (reg_addr == shsc_pkg::SEL_ADDR);
  assign sel_wr           = reg_wr && sel_hit;
  assign settle_code_bit2 = osc_settle_select_r[2];
  assign settle_code_bit1 = osc_settle_select_r[1];
  assign settle_code_bit0 = osc_settle_select_r[0];

  // Count only once the oscillator reports it is oscillating
  assign settle_run = (state_r == shsc_pkg::ST_SETTLE);

  // HALT release decode; a masked request is simply not seen
  assign halt_wake     = nmi_pend || unmasked_q;
  assign halt_wake_vec = nmi_pend || ie_q;
  assign resume_end    = (resume_cnt_r <= 4'h1);

  // STOP with a request already pending is served as HALT plus settle
  assign stop_pend_go = (state_r == shsc_pkg::ST_RUN) && !halt_exec &&
                        stop_exec && unmasked_q;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt      = state_r;
    resume_cnt_nxt = resume_cnt_r;
    resume_vec_nxt = resume_vec_r;
    settle_start   = 1'b0;
    nmi_clear      = 1'b0;
    case (state_r)
      shsc_pkg::ST_RUN: begin
        if (halt_exec) begin
          state_nxt = shsc_pkg::ST_HALT;
        end else if (stop_exec && unmasked_q) begin
          state_nxt    = shsc_pkg::ST_SETTLE;
          settle_start = 1'b1;
        end else if (stop_exec) begin
          state_nxt = shsc_pkg::ST_STOP;
        end
      end
      shsc_pkg::ST_HALT: begin
        if (halt_wake) begin
          state_nxt      = shsc_pkg::ST_RESUME;
          resume_vec_nxt = halt_wake_vec;
          resume_cnt_nxt = halt_wake_vec ? shsc_pkg::VEC_LOAD
                                         : shsc_pkg::NEXT_LOAD;
          nmi_clear      = 1'b1;
        end
      end
      shsc_pkg::ST_STOP: begin
        if (unmasked_q) begin
          state_nxt    = shsc_pkg::ST_OSC_WAIT;
          settle_start = 1'b1;
        end
      end
      shsc_pkg::ST_OSC_WAIT: begin
        if (osc_running) begin
          state_nxt = shsc_pkg::ST_SETTLE;
        end
      end
      shsc_pkg::ST_SETTLE: begin
        if (settle_done && from_reset_r) begin
          state_nxt = shsc_pkg::ST_RUN;
        end else if (settle_done) begin
          state_nxt      = shsc_pkg::ST_RESUME;
          resume_vec_nxt = ie_q;
          resume_cnt_nxt = ie_q ? shsc_pkg::VEC_LOAD
                                : shsc_pkg::NEXT_LOAD;
        end
      end
      shsc_pkg::ST_RESUME: begin
        if (resume_end) begin
          state_nxt = shsc_pkg::ST_RUN;
        end else begin
          resume_cnt_nxt = resume_cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = shsc_pkg::ST_RUN;
      end
    endcase
  end

  // Peripheral clocks stop only while the oscillator is dark
  assign stop_like_nxt = (state_nxt == shsc_pkg::ST_STOP) ||
                         (state_nxt == shsc_pkg::ST_OSC_WAIT);

  // ------------------------------------------------------------------
  // State registers; reset, even from HALT, restarts via settling
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r      <= shsc_pkg::ST_OSC_WAIT;
      resume_cnt_r <= 4'h0;
      resume_vec_r <= 1'b0;
      from_reset_r <= 1'b1;
      halt_hold_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      if (stop_pend_go) begin
        halt_hold_r <= 1'b1;
      end else if (state_nxt != shsc_pkg::ST_SETTLE) begin
        halt_hold_r <= 1'b0;
      end
      resume_cnt_r <= resume_cnt_nxt;
      resume_vec_r <= resume_vec_nxt;
      if (settle_done) begin
        from_reset_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Settle select register; standby never clears it
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      osc_settle_select_r <= shsc_pkg::SEL_RESET[2:0];
      reg_rdata           <= 8'h00;
    end else begin
      if (sel_wr) begin
        osc_settle_select_r <=
          reg_wdata[shsc_pkg::SEL_LSB +: shsc_pkg::SEL_W];
      end
      reg_rdata <= (reg_rd && sel_hit) ?
                   {5'h00, settle_code_bit2, settle_code_bit1,
                    settle_code_bit0} : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // CPU side outputs; clock, oscillator and mode flags from the next state, wake pulses from the current state
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_clk_en    <= 1'b0;
      osc_enable    <= 1'b1;
      wake_vectored <= 1'b0;
      wake_next     <= 1'b0;
      reset_branch  <= 1'b0;
      halt_mode     <= 1'b0;
      stop_mode     <= 1'b0;
    end else begin
      // In HALT only the CPU clock is gated; no state is touched
      cpu_clk_en    <= (state_nxt == shsc_pkg::ST_RUN);
      osc_enable    <= (state_nxt != shsc_pkg::ST_STOP);
      wake_vectored <= (state_r == shsc_pkg::ST_RESUME) &&
                       resume_end && resume_vec_r;
      wake_next     <= (state_r == shsc_pkg::ST_RESUME) &&
                       resume_end && !resume_vec_r;
      reset_branch  <= settle_done && from_reset_r;
      halt_mode     <= (state_nxt == shsc_pkg::ST_HALT) ||
                       ((state_nxt == shsc_pkg::ST_SETTLE) &&
                        (stop_pend_go || halt_hold_r));
      stop_mode     <= stop_like_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Peripheral run enables
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      timer16_run <= 1'b0;
      timer8_run  <= 1'b0;
      wdt_run     <= 1'b0;
      serial_run  <= 1'b0;
      ext_int_run <= 1'b1;
    end else begin
      timer16_run <= !stop_like_nxt;
      wdt_run     <= !stop_like_nxt;
      timer8_run  <= !stop_like_nxt ||
                     timer_external_count_input_sel;
      serial_run  <= !stop_like_nxt || serial_ext_clk_sel;
      ext_int_run <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_vec_release;
    state_r == shsc_pkg::ST_HALT && halt_wake && halt_wake_vec;
  endsequence

  sequence s_next_release;
    state_r == shsc_pkg::ST_HALT && !nmi_pend && unmasked_q && !ie_q;
  endsequence

  sequence s_stop_pending;
    state_r == shsc_pkg::ST_RUN && !halt_exec && stop_exec &&
    unmasked_q;
  endsequence

  a_halt_gates_cpu: assert property (
    state_r == shsc_pkg::ST_HALT |-> !cpu_clk_en && osc_enable)
    else $error("HALT left the CPU clock on or oscillator off");

  a_stop_osc_off: assert property (
    state_r == shsc_pkg::ST_RUN && !halt_exec && stop_exec &&
    !unmasked_q |=> !osc_enable && state_r == shsc_pkg::ST_STOP)
    else $error("STOP did not stop the oscillator");

  a_sel_retained: assert property (
    !sel_wr |=> $stable(osc_settle_select_r))
    else $error("Settle select changed without a write");

  a_halt_periph_run: assert property (
    state_r == shsc_pkg::ST_HALT && $past(state_r) ==
    shsc_pkg::ST_HALT |-> timer16_run && wdt_run && timer8_run &&
    serial_run && ext_int_run)
    else $error("Peripheral stopped during HALT");

  a_next_release: assert property (
    s_next_release |=> state_r == shsc_pkg::ST_RESUME && !resume_vec_r)
    else $error("Unmasked request did not resume to next");

  a_masked_holds: assert property (
    state_r == shsc_pkg::ST_HALT && !unmasked_q && !nmi_pend
    |=> state_r == shsc_pkg::ST_HALT)
    else $error("HALT left without an unmasked request");

  a_vec_latency: assert property (
    s_vec_release |-> ##9 (wake_vectored && cpu_clk_en))
    else $error("Vectored resume not at nine clocks");

  a_next_latency: assert property (
    s_next_release |-> ##2 (wake_next && cpu_clk_en))
    else $error("Plain resume not at two clocks");

  a_nmi_release: assert property (
    state_r == shsc_pkg::ST_HALT && nmi_pend
    |=> state_r == shsc_pkg::ST_RESUME && resume_vec_r)
    else $error("NMI did not force vectored release");

  a_stop_pending: assert property (
    s_stop_pending |=> state_r == shsc_pkg::ST_SETTLE && osc_enable &&
    halt_mode)
    else $error("Pending request let STOP darken the oscillator");

  a_stop_periph: assert property (
    state_r == shsc_pkg::ST_STOP |-> !timer16_run && !wdt_run &&
    ext_int_run)
    else $error("Timer or watchdog running in STOP");

  a_stop_timer8: assert property (
    state_r == shsc_pkg::ST_STOP && $past(state_r) ==
    shsc_pkg::ST_STOP |-> timer8_run ==
    $past(timer_external_count_input_sel))
    else $error("8-bit timer enable wrong in STOP");

  a_stop_serial: assert property (
    state_r == shsc_pkg::ST_STOP && $past(state_r) ==
    shsc_pkg::ST_STOP |-> serial_run == $past(serial_ext_clk_sel))
    else $error("Serial enable wrong in STOP");

  a_stop_release: assert property (
    state_r == shsc_pkg::ST_STOP && unmasked_q
    |=> state_r == shsc_pkg::ST_OSC_WAIT && osc_enable && !cpu_clk_en &&
    settle_busy)
    else $error("Interrupt did not release STOP");

  a_settle_resume: assert property (
    state_r == shsc_pkg::ST_SETTLE && settle_done && !from_reset_r
    |=> state_r == shsc_pkg::ST_RESUME && resume_vec_r == $past(ie_q))
    else $error("Wrong resume kind after STOP settle");

  a_reset_branch: assert property (
    reset_branch |-> cpu_clk_en && !$past(cpu_clk_en) &&
    $past(state_r) == shsc_pkg::ST_SETTLE)
    else $error("Reset branch without completed settle");

endmodule

//--- tb/shsc_osc_model.sv
// Oscillator model with a start-up delay after each enable
`timescale 1ns/1ns
module shsc_osc_model #(
  parameter int START_DLY = 5
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Oscillator link
  input  wire logic osc_enable,
  output logic      osc_running
);
  logic [7:0] start_cnt_r;

  // Start-up gap lies outside the settle count, so it is never zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst || !osc_enable) begin
      start_cnt_r <= 8'h00;
      osc_running <= 1'b0;
    end else if (start_cnt_r < 8'(START_DLY)) begin
      start_cnt_r <= start_cnt_r + 8'h01;
    end else begin
      osc_running <= 1'b1;
    end
  end
endmodule

//--- tb/shsc_standby_ctrl_bench.sv
// Self-checking bench of the standby controller
`timescale 1ns/1ns
module shsc_standby_ctrl_bench;
  localparam int SH = 8;
  localparam int MD = 16;
  localparam int LG = 32;
  logic        clock, sys_rst, halt_exec, stop_exec, interrupt_enable_flag;
  logic        nmi_req, osc_running, osc_enable, reg_wr, reg_rd;
  logic        cpu_clk_en, wake_vectored, wake_next, reset_branch;
  logic        timer_external_count_input_sel, serial_ext_clk_sel;
  logic        timer16_run, timer8_run, wdt_run, serial_run, ext_int_run;
  logic        halt_mode, stop_mode;
  logic [7:0]  irq_req, interrupt_mask_flag, reg_wdata, reg_rdata, rd_v, wv;
  logic [15:0] reg_addr;
  integer      seed, num_errors, n_checks, n, k;

  // Short settle counts keep the run brief
  shsc_standby_ctrl #(.CNT_W(13), .SHORT_CYC(SH), .MID_CYC(MD),
    .LONG_CYC(LG)) dut (
    .clock, .sys_rst, .halt_exec, .stop_exec, .interrupt_enable_flag,
    .irq_req, .interrupt_mask_flag, .nmi_req, .osc_running, .osc_enable,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_clk_en,
    .wake_vectored, .wake_next, .reset_branch,
    .timer_external_count_input_sel, .serial_ext_clk_sel, .timer16_run,
    .timer8_run, .wdt_run, .serial_run, .ext_int_run, .halt_mode,
    .stop_mode);
  shsc_osc_model osc (.clock, .sys_rst, .osc_enable, .osc_running);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function int settle(input logic [2:0] c);
    return c == 3'h0 ? SH : c == 3'h2 ? MD : LG;
  endfunction
  // One-cycle instruction strobe, then one cycle for the mode to land
  task strobe(input logic h);
    @(posedge clock);
    halt_exec <= h;
    stop_exec <= !h;
    @(posedge clock);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // Counts live-oscillator cycles up to a resume pulse; NMI is one cycle
  task wait_evt(input int lo, input int hi);
    n = 0;
    do begin
      @(posedge clock);
      nmi_req <= 1'b0;
      #1 if (osc_running) n++;
    end while (!(wake_vectored | wake_next | reset_branch) && n < 300);
    chk("latency", 8'(n >= lo && n <= hi), 8'h01);
  endtask
  task halt_wake(input logic ie, input logic nmi);
    k = $unsigned($random(seed)) % 8;
    interrupt_enable_flag <= ie;
    strobe(1'b1);
    chk("halt", {cpu_clk_en, halt_mode, osc_enable, timer16_run, wdt_run,
      serial_run, timer8_run, ext_int_run}, 8'h7F);
    @(posedge clock);
    interrupt_mask_flag <= 8'hFF;
    irq_req[k] <= 1'b1;
    repeat (12) @(posedge clock);
    #1 chk("masked", 8'({halt_mode, cpu_clk_en}), 8'h02);
    @(posedge clock);
    nmi_req <= nmi;
    interrupt_mask_flag[k] <= nmi;
    wait_evt((ie | nmi) ? 9 : 1, (ie | nmi) ? 11 : 3);
    chk("vector", 8'({wake_vectored, wake_next, cpu_clk_en}),
      8'({ie | nmi, !(ie | nmi), 1'b1}));
    @(posedge clock);
    irq_req <= 8'h00;
    interrupt_mask_flag <= 8'h00;
  endtask
  task stop_wake(input logic [2:0] c, input logic ie, input logic pend);
    wr(16'hFFFA, 8'(c));
    k = $unsigned($random(seed)) % 8;
    @(posedge clock);
    interrupt_enable_flag <= ie;
    irq_req[k] <= pend;
    timer_external_count_input_sel <= 1'($random(seed));
    serial_ext_clk_sel <= 1'($random(seed));
    strobe(1'b0);
    chk("mode", 8'({stop_mode, halt_mode, osc_enable}), pend ? 8'h3 : 8'h4);
    if (!pend) begin
      chk("stop_run", 8'({timer16_run, wdt_run, ext_int_run, timer8_run,
        serial_run}), 8'({3'b001, timer_external_count_input_sel,
        serial_ext_clk_sel}));
      repeat (4) @(posedge clock);
      irq_req[k] <= 1'b1;
    end
    wait_evt(settle(c) + (ie ? 7 : -1), settle(c) + (ie ? 13 : 5));
    chk("vector", 8'({wake_vectored, wake_next, cpu_clk_en}),
      8'({ie, !ie, 1'b1}));
    rd(16'hFFFA);
    chk("kept", rd_v, 8'(c));
    @(posedge clock);
    irq_req <= 8'h00;
  endtask
  task reset_in(input logic h);
    strobe(h);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("rst", 8'({cpu_clk_en, osc_enable}), 8'h01);
    @(posedge clock);
    sys_rst <= 1'b0;
    wait_evt(MD, MD + 4);
    chk("branch", 8'(reset_branch), 8'h01);
  endtask

  // Main sequence
  initial begin
    seed = 91907;
    num_errors = 0;
    n_checks = 0;
    {halt_exec, stop_exec, interrupt_enable_flag, nmi_req} = 4'h0;
    {reg_wr, reg_rd, timer_external_count_input_sel} = 3'h0;
    serial_ext_clk_sel = 1'b0;
    {irq_req, interrupt_mask_flag, reg_wdata, reg_addr} = 32'h0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    wait_evt(MD, MD + 4);
    rd(16'hFFFA);
    chk("reset_val", rd_v, 8'h04);
    rd(16'hFFF0);
    chk("unmapped", rd_v, 8'h00);
    for (int i = 0; i < 6; i++) begin
      // Only the permitted settle codes are written
      wv = 8'($random(seed)) & 8'hF8;
      wv[2:0] = 3'(2 * ($unsigned($random(seed)) % 3));
      wr(16'hFFFA, wv);
      rd(16'hFFFA);
      chk("sel", rd_v, {5'h0, wv[2:0]});
    end
    halt_wake(1'b1, 1'b0);
    halt_wake(1'b0, 1'b0);
    halt_wake(1'b0, 1'b1);
    halt_wake(1'($random(seed)), 1'b0);
    stop_wake(3'h0, 1'b1, 1'b0);
    stop_wake(3'h2, 1'b0, 1'b0);
    stop_wake(3'h4, 1'($random(seed)), 1'b0);
    stop_wake(3'h0, 1'b1, 1'b1);
    reset_in(1'b1);
    reset_in(1'b0);
    print_verdict;
  end

  // Watchdog against a hang
  initial begin
    #500000;
    num_errors++;
    print_verdict;
  end
endmodule
